// [common/reset_seq_defines.vh]
/*
 Register offsets, field positions, reset values and timing counts for the reset and brown-out sequencer.
 Assumes inclusion by bare name from design files; definitions only.
*/
// Contract
// - Merge all reset sources into one core reset
// - Hold reset while power-on detector is low
// - Power-up delay nominally 64 ms when enabled
// - Hold reset while power-up delay runs
// - Delay enabled only when enable_n is zero
// - Delay starts after power-on/brown-out release
// - Four brown-out modes; code 00 always off
// - Modes 11/10 wait for ready and supply
// - Mode 11 active in sleep, wake immediate
// - Mode 10 off in sleep, wake waits ready
// - Mode 01 soft enable bit controls detection
// - Soft mode start-up does not wait
// - Soft mode protection starts when circuit ready
// - Soft mode protection unchanged by sleep
// - Soft enable bit ineffective outside mode 01
// - Bit 0 reads brown-out circuit ready
// - Soft enable bit 7 resets 1; 6-1 zero
// - Brown-out only after dip exceeds filter duration
// - Run only after timers done and clear released
`ifndef RESET_SEQ_DEFINES_VH
`define RESET_SEQ_DEFINES_VH

`define BROWNOUT_CONTROL_ADDR 12'h000
`define SEQ_STATUS_ADDR       12'h004
`define SOFT_ENABLE_BIT       7
`define CIRCUIT_READY_BIT     0
`define SOFT_ENABLE_RESET     1'b1

`define MODE_OFF    2'b00
`define MODE_SOFT   2'b01
`define MODE_NSLEEP 2'b10
`define MODE_ON     2'b11

`define CLK_HZ             100000000
`define SLOW_TICK_HZ       31000
`define SLOW_DIV_COUNT     (`CLK_HZ / `SLOW_TICK_HZ)
`define POWER_UP_DELAY_MS  64
`define POWER_UP_TICKS     ((`SLOW_TICK_HZ * `POWER_UP_DELAY_MS) / 1000)
`define FILTER_NS          1000
`define FILTER_CYCLES      ((`FILTER_NS * (`CLK_HZ / 1000000)) / 1000)

`endif

// [dv/analog_detector_model.sv]
/*
 Model of the analog power-on and brown-out detectors.
 Assumes the bench sets supply and circuit power levels.
*/
`timescale 1ns/10ps
module analog_detector_model #(
	parameter READY_DLY = 4
) (
	input wire  hclk,
	input wire  vdd_on,
	input wire  vdd_hi,
	input wire  bo_pwr,
	output wire power_on_ok,
	output wire supply_above_threshold,
	output reg  brownout_circuit_ready = 1'b0
);
	reg [3:0] cnt = 4'h0;
	assign power_on_ok = vdd_on;
	assign supply_above_threshold = vdd_on && vdd_hi;
	// Circuit settles for a while, so ready lags power
	always @(posedge hclk) begin
		cnt <= bo_pwr ? ((cnt < READY_DLY) ? cnt + 4'h1 : cnt) : 4'h0;
		brownout_circuit_ready <= bo_pwr && (cnt == READY_DLY);
	end
endmodule // analog_detector_model

// [dv/reset_brownout_sequencer_monitor.sv]
/*
 Port checker for the reset and brown-out sequencer.
 Assumes binding into the sequencer, whose hready follows hreadyout.
*/
`timescale 1ns/10ps
module reset_brownout_sequencer_monitor #(
	parameter FILTER_LEN = 3
) (
	input wire       hclk,
	input wire       hresetn,
	input wire       power_on_ok,
	input wire       supply_above_threshold,
	input wire       brownout_circuit_ready,
	input wire [1:0] brownout_mode_select,
	input wire       sleep_mode,
	input wire       external_master_clear_n,
	input wire       watchdog_reset,
	input wire       programming_exit,
	input wire       core_reset,
	input wire       brownout_enable,
	input wire       wake_hold,
	input wire       brownout_reset_event
);
	// One clock domain, so one clocking and one disable
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_POR: assert property (!power_on_ok |-> ##[1:2] core_reset)
		else $error("core not held while supply is low");
	AST_SRC: assert property (!external_master_clear_n || watchdog_reset || programming_exit |-> ##[1:2] core_reset)
		else $error("reset source did not reach the core");
	AST_OFF: assert property (brownout_mode_select == 2'b00 [*2] |-> !brownout_enable)
		else $error("detection on in off mode");
	AST_ON: assert property (brownout_mode_select == 2'b11 [*2] |-> brownout_enable && !wake_hold)
		else $error("always-on mode not active or wake held");
	AST_NSL: assert property ((brownout_mode_select == 2'b10 && sleep_mode) [*2] |-> !brownout_enable)
		else $error("detection on in sleep");
	AST_WAKE: assert property ((brownout_mode_select == 2'b10 && !brownout_circuit_ready) [*2] |-> wake_hold)
		else $error("wake not held for circuit");
	AST_SOFT: assert property ((brownout_mode_select == 2'b01 && !brownout_circuit_ready) [*2] |-> !brownout_enable)
		else $error("soft detection before circuit ready");
	AST_FILT: assert property ($rose(brownout_reset_event) |-> !$past(supply_above_threshold, FILTER_LEN))
		else $error("brown-out event on a short dip");
	AST_NOBO: assert property (!brownout_enable [*2] |-> !$rose(brownout_reset_event))
		else $error("brown-out event with detection off");
endmodule // reset_brownout_sequencer_monitor

// [dv/reset_brownout_sequencer_tb.sv]
/*
 Bench for the reset sequencer: bus tasks, power cycles and dips.
 Assumes hready fed back from hreadyout and a short delay count.
*/
`timescale 1ns/10ps
module reset_brownout_sequencer_tb;
	reg hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, vdd_on = 0, vdd_hi = 1, bo_pwr = 0;
	reg [31:0] haddr = 0, hwdata = 0, rd;
	reg [1:0] htrans = 0, brownout_mode_select = 0;
	reg [2:0] hsize = 3'h2;
	reg [5:0] src = 0;
	reg power_up_timer_enable_n = 1, sleep_mode = 0, oscillator_started = 1;
	wire [31:0] hrdata;
	wire hreadyout, hresp, power_on_ok, supply_above_threshold, brownout_circuit_ready;
	wire core_reset, brownout_enable, wake_hold, brownout_reset_event;
	wire hready = hreadyout;
	integer error_cnt = 0, samples_checked = 0, cyc = 0, i;
	reset_brownout_sequencer #(.POWER_UP_TICKS(5), .SLOW_DIV(4), .FILTER_LEN(3)) dut (.*,
		.watchdog_reset(src[0]), .reset_instruction(src[1]), .stack_overflow(src[2]),
		.stack_underflow(src[3]), .programming_exit(src[4]), .external_master_clear_n(~src[5]));
	analog_detector_model det (.*);
	initial forever #5 hclk = ~hclk;
	task check(input [31:0] e, input [31:0] g);
		samples_checked = samples_checked + 1;
		if (e !== g) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Single word transfer; entered just after a rising edge
	task bus(input w, input [31:0] a, input [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		check(32'h0000_0000, {hresp, ~hreadyout});
	endtask
	task pw(input integer n);
		vdd_on <= 0;
		repeat (3) @(posedge hclk);
		check(1, core_reset);
		vdd_on <= 1;
		repeat (n) @(posedge hclk);
	endtask
	task dip(input integer n, input [31:0] e);
		vdd_hi <= 0;
		repeat (n) @(posedge hclk);
		check(e, brownout_reset_event);
		vdd_hi <= 1;
		repeat (30) @(posedge hclk);
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Hang guard well above the expected run
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt = error_cnt + 1;
			results;
		end
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		bus(0, 0, 0);
		check(32'h0000_0080, rd);
		bus(1, 0, 0);
		bus(0, 0, 0);
		check(0, rd);
		bus(1, 0, 32'hffff_ffff);
		bus(0, 32'h0000_0010, 0);
		check(0, rd);
		bo_pwr <= 1;
		pw(10);
		bus(0, 0, 0);
		check(32'h0000_0081, rd);
		bus(0, 32'h0000_0004, 0);
		check(32'h0000_0008, rd);
		$display("register test done");
		power_up_timer_enable_n <= 0;
		pw(12);
		check(1, core_reset);
		vdd_on <= 0;
		@(posedge hclk);
		vdd_on <= 1;
		repeat (14) @(posedge hclk);
		check(1, core_reset);
		repeat (30) @(posedge hclk);
		check(0, core_reset);
		power_up_timer_enable_n <= 1;
		pw(6);
		check(0, core_reset);
		for (i = 0; i < 6; i = i + 1) begin
			src <= 6'h01 << i;
			repeat (3) @(posedge hclk);
			check(1, core_reset);
			src <= 0;
			repeat (8) @(posedge hclk);
			check(0, core_reset);
		end
		oscillator_started <= 0;
		repeat (3) @(posedge hclk);
		check(1, core_reset);
		oscillator_started <= 1;
		repeat (3) @(posedge hclk);
		check(0, core_reset);
		$display("sequence test done");
		brownout_mode_select <= 2'b11;
		bo_pwr <= 0;
		pw(20);
		check(1, core_reset);
		bo_pwr <= 1;
		repeat (12) @(posedge hclk);
		check(0, core_reset);
		brownout_mode_select <= 2'b01;
		bo_pwr <= 0;
		pw(8);
		check(0, core_reset);
		$display("start-up test done");
		bo_pwr <= 1;
		repeat (8) @(posedge hclk);
		dip(9, 1);
		dip(2, 0);
		bus(1, 0, 0);
		dip(9, 0);
		brownout_mode_select <= 2'b00;
		dip(9, 0);
		brownout_mode_select <= 2'b10;
		dip(9, 1);
		bo_pwr <= 0;
		repeat (3) @(posedge hclk);
		check(1, wake_hold);
		bo_pwr <= 1;
		repeat (8) @(posedge hclk);
		check(0, wake_hold);
		sleep_mode <= 1;
		dip(9, 0);
		brownout_mode_select <= 2'b11;
		dip(9, 1);
		$display("dip test done");
		results;
	end
endmodule // reset_brownout_sequencer_tb
bind reset_brownout_sequencer reset_brownout_sequencer_monitor #(.FILTER_LEN(FILTER_LEN)) mon (.*);

// [rtl/dip_filter.v]
/*
 Low-supply filter: flags a fault only after the input has stayed low for more than LEN cycles.
 Assumes input is synchronous to hclk.
*/
`timescale 1ns/10ps
module dip_filter #(
	parameter LEN = 100
) (
	input  wire hclk,
	input  wire hresetn,
	input  wire enable,
	input  wire supply_ok,
	output reg  fault
);
	reg [15:0] low_count;

	// Short dips reset the counter, so only a sustained low trips
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_count <= 16'h0000;
			fault     <= 1'b0;
		end else if (!enable || supply_ok) begin
			low_count <= 16'h0000;
			fault     <= 1'b0;
		end else if (low_count > LEN[15:0]) begin
			fault     <= 1'b1;
		end else begin
			low_count <= low_count + 16'h0001;
		end
	end
endmodule // dip_filter

// [rtl/reset_brownout_sequencer.v]
/*
 Reset sequencer: merges reset sources, applies brown-out supervision and the power-up delay,
 and exposes the brownout_control register over AHB-Lite.
 Assumes analog detector outputs and strap inputs are synchronous to hclk and that the
 bus master issues only single word transfers.
*/
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "reset_seq_defines.vh"
module reset_brownout_sequencer #(
	parameter POWER_UP_TICKS = `POWER_UP_TICKS,
	parameter SLOW_DIV       = `SLOW_DIV_COUNT,
	parameter FILTER_LEN     = `FILTER_CYCLES
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        power_on_ok,
	input  wire        supply_above_threshold,
	input  wire        brownout_circuit_ready,
	input  wire [1:0]  brownout_mode_select,
	input  wire        power_up_timer_enable_n,
	input  wire        sleep_mode,
	input  wire        external_master_clear_n,
	input  wire        watchdog_reset,
	input  wire        reset_instruction,
	input  wire        stack_overflow,
	input  wire        stack_underflow,
	input  wire        programming_exit,
	input  wire        oscillator_started,
	output reg         core_reset,
	output reg         brownout_enable,
	output reg         wake_hold,
	output reg         brownout_reset_event
);
	localparam ST_HOLD  = 4'b0001;
	localparam ST_WAIT  = 4'b0010;
	localparam ST_DELAY = 4'b0100;
	localparam ST_RUN   = 4'b1000;

	reg  [3:0]  state;
	reg  [3:0]  next_state;
	reg  [23:0] delay_count;
	reg         soft_brownout_enable;
	reg         seq_phase_addr;
	reg         seq_phase_write;
	reg         seq_phase_valid;
	wire        slow_tick;
	wire        filter_fault;
	reg         detect_active;
	reg         startup_ready;
	reg         por_bor_hold;
	reg         other_reset;

	// Slow tick standing in for the low-frequency internal clock
	tick_divider #(
		.DIV (SLOW_DIV)
	) u_div (
		.hclk    (hclk),
		.hresetn (hresetn),
		.tick    (slow_tick)
	);

	// Detection enable per mode; soft bit only matters in mode 01
	always @* begin
		case (brownout_mode_select)
			`MODE_ON:     detect_active = 1'b1;
			`MODE_NSLEEP: detect_active = !sleep_mode;
			`MODE_SOFT:   detect_active = soft_brownout_enable && brownout_circuit_ready;
			default:      detect_active = 1'b0;
		endcase
	end

	// Start-up gate: supervised modes wait for ready and supply
	always @* begin
		case (brownout_mode_select)
			`MODE_ON,
			`MODE_NSLEEP: startup_ready = brownout_circuit_ready && supply_above_threshold;
			default:      startup_ready = 1'b1;
		endcase
	end

	dip_filter #(
		.LEN (FILTER_LEN)
	) u_filter (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.enable    (detect_active),
		.supply_ok (supply_above_threshold),
		.fault     (filter_fault)
	);

	// Reset sources: power-on, brown-out and programming exit restart the sequence; the others only hold the core
	always @* begin
		por_bor_hold = !power_on_ok || filter_fault || programming_exit;
		other_reset  = !external_master_clear_n || watchdog_reset || reset_instruction ||
		               stack_overflow || stack_underflow;
	end

	// Sequence: hold, wait for supervisor, delay, run
	always @* begin
		next_state = state;
		case (state)
			ST_HOLD: begin
				if (!por_bor_hold)
					next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (por_bor_hold)
					next_state = ST_HOLD;
				else if (startup_ready)
					next_state = power_up_timer_enable_n ? ST_RUN : ST_DELAY;
			end
			ST_DELAY: begin
				if (por_bor_hold)
					next_state = ST_HOLD;
				else if (delay_count >= POWER_UP_TICKS[23:0])
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (por_bor_hold)
					next_state = ST_HOLD;
			end
			default: next_state = ST_HOLD;
		endcase
	end

	// State and power-up delay counter; counter clears on every new release
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state       <= ST_HOLD;
			delay_count <= 24'h00_0000;
		end else begin
			state <= next_state;
			if (state != ST_DELAY)
				delay_count <= 24'h00_0000;
			else if (slow_tick)
				delay_count <= delay_count + 24'h00_0001;
		end
	end

	// Registered outputs; core runs only when sequence, oscillator and clear all allow
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_reset           <= 1'b1;
			brownout_enable      <= 1'b0;
			wake_hold            <= 1'b0;
			brownout_reset_event <= 1'b0;
		end else begin
			core_reset           <= (state != ST_RUN) || por_bor_hold || other_reset ||
			                        !oscillator_started;
			brownout_enable      <= detect_active;
			wake_hold            <= (brownout_mode_select == `MODE_NSLEEP) && !brownout_circuit_ready;
			brownout_reset_event <= filter_fault;
		end
	end

	// AHB-Lite address phase capture
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_phase_valid  <= 1'b0;
			seq_phase_write  <= 1'b0;
			seq_phase_addr   <= 1'b0;
		end else if (hready) begin
			seq_phase_valid  <= hsel && htrans[1];
			seq_phase_write  <= hwrite;
			seq_phase_addr   <= (haddr[11:0] == `BROWNOUT_CONTROL_ADDR);
		end
	end

	// Software enable bit: writable in every mode, effective only in mode 01
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			soft_brownout_enable <= `SOFT_ENABLE_RESET;
		else if (seq_phase_valid && seq_phase_write && seq_phase_addr)
			soft_brownout_enable <= hwdata[`SOFT_ENABLE_BIT];
	end

	// Read data; zero-wait answers, unmapped reads as zero
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				if (haddr[11:0] == `BROWNOUT_CONTROL_ADDR)
					hrdata <= {24'h00_0000, soft_brownout_enable, 6'b00_0000,
					           brownout_circuit_ready};
				else if (haddr[11:0] == `SEQ_STATUS_ADDR)
					hrdata <= {24'h00_0000, 4'h0, state};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end
endmodule // reset_brownout_sequencer

// [rtl/tick_divider.v]
/*
 Divider producing a one-cycle enable pulse every DIV clock cycles.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module tick_divider #(
	parameter DIV = 3225
) (
	input  wire hclk,
	input  wire hresetn,
	output reg  tick
);
	reg [15:0] count;

	// Count up and pulse at the wrap
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 16'h0000;
			tick  <= 1'b0;
		end else if (count == DIV[15:0] - 16'h0001) begin
			count <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 16'h0001;
			tick  <= 1'b0;
		end
	end
endmodule // tick_divider
